// [sim/tcf_partner.sv]
// Far side model: trigger pin and counter event source
`timescale 1ns/100ps
module tcf_partner (
    // Clock
    input wire logic core_clk_in,
    // Pin and counter events
    output logic pin_out,
    output logic rollover_out,
    output logic underflow_out,
    output logic count_down_out,
    output logic equal_out
);
    initial begin
        pin_out = 1'b1;
        rollover_out = 1'b0;
        underflow_out = 1'b0;
        count_down_out = 1'b0;
        equal_out = 1'b0;
    end
    // Low long enough to pass the synchroniser
    task automatic pin_fall();
        @(posedge core_clk_in);
        pin_out <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        pin_out <= 1'b1;
        repeat (4) @(posedge core_clk_in);
    endtask : pin_fall
    // Kind 0 rollover, 1 underflow, 2 down count match
    task automatic event_pulse(input int kind);
        @(posedge core_clk_in);
        rollover_out <= (kind == 0);
        underflow_out <= (kind == 1);
        count_down_out <= (kind == 2);
        equal_out <= (kind == 2);
        @(posedge core_clk_in);
        {rollover_out, underflow_out, count_down_out, equal_out} <= 4'h0;
        repeat (2) @(posedge core_clk_in);
    endtask : event_pulse
endmodule : tcf_partner

// [sim/tcf_timer2_flags_bench.sv]
// Self-checking bench for the second timer control and flag block
`timescale 1ns/100ps
module tcf_timer2_flags_bench;
    import tcf_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] rdata;
    logic pin, roll, under, down, equal;
    logic rx_sel, tx_sel, baud, run, src, dce, cap, rel, ext_cnt, irq;
    logic [7:0] exp_q[$];
    logic [7:0] r;
    int error_cnt = 0;
    int checks = 0;
    int n_rel = 0;
    int n_cap = 0;
    int n_ext = 0;
    logic [7:0] pin_ctrl[4] = '{8'h08, 8'h00, 8'h18, 8'h0f};
    logic [7:0] pin_exp[4] = '{8'h48, 8'h00, 8'h18, 8'h4f};

    tcf_partner tcf_partner_inst (.core_clk_in(core_clk_in), .pin_out(pin), .rollover_out(roll),
        .underflow_out(under), .count_down_out(down), .equal_out(equal));
    tcf_timer2_flags tcf_timer2_flags_inst (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .external_trigger_pin_in(pin), .timer_rollover_in(roll), .timer_underflow_in(under),
        .timer_count_down_in(down), .count_equals_capture_in(equal), .rx_baud_from_timer2_out(rx_sel),
        .tx_baud_from_timer2_out(tx_sel), .baud_generator_mode_out(baud), .second_timer_run_out(run),
        .count_source_select_out(src), .down_count_enable_out(dce), .capture_strobe_out(cap),
        .reload_strobe_out(rel), .external_count_pulse_out(ext_cnt), .irq_out(irq));

    initial begin
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_in);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_in);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(exp);
        @(posedge core_clk_in);
        rd <= 1'b0;
    endtask : rd_reg

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    // Read data checked mid-cycle, against the oldest note
    always @(posedge core_clk_in) rd_d <= rd;
    always @(negedge core_clk_in) begin
        if (rd_d) begin
            if (exp_q.size() == 0) chk("read queue", 8'h01, 8'h00);
            else chk("read data", exp_q.pop_front(), rdata);
        end else if (rdata !== 8'h00) chk("idle read data", 8'h00, rdata);
    end
    always @(posedge core_clk_in) if (rel === 1'b1) n_rel++;
    always @(posedge core_clk_in) if (cap === 1'b1) n_cap++;
    always @(posedge core_clk_in) if (ext_cnt === 1'b1) n_ext++;

    initial begin
        repeat (20000) @(posedge core_clk_in);
        chk("timeout", 8'h00, 8'h01);
        conclude();
    end

    initial begin
        void'($urandom(32'hf7fe));
        repeat (10) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        rd_reg(TCF_CTRL_ADDR, TCF_CTRL_RST);
        rd_reg(TCF_IRQ_STATUS_ADDR, 8'h00);
        rd_reg(TCF_IRQ_MASK_ADDR, 8'h00);
        rd_reg(TCF_MODE_ADDR, 8'h00);
        wr_reg(8'hc9, 8'hff);
        rd_reg(8'hc9, 8'h00);
        $display("test reset done");
        repeat (4) begin
            r = 8'($urandom());
            wr_reg(TCF_CTRL_ADDR, r);
            rd_reg(TCF_CTRL_ADDR, r);
            chk("rx select", {7'h00, r[5]}, {7'h00, rx_sel});
            chk("tx select", {7'h00, r[4]}, {7'h00, tx_sel});
            chk("baud mode", {7'h00, r[5] | r[4]}, {7'h00, baud});
            chk("run", {7'h00, r[2]}, {7'h00, run});
            chk("count source", {7'h00, r[1]}, {7'h00, src});
        end
        $display("test software writes done");
        wr_reg(TCF_CTRL_ADDR, 8'h00);
        wr_reg(TCF_IRQ_STATUS_ADDR, 8'h03);
        wr_reg(TCF_IRQ_MASK_ADDR, 8'h01);
        tcf_partner_inst.event_pulse(0);
        rd_reg(TCF_CTRL_ADDR, 8'h80);
        rd_reg(TCF_IRQ_STATUS_ADDR, 8'h01);
        chk("irq", 8'h01, {7'h00, irq});
        wr_reg(TCF_IRQ_STATUS_ADDR, 8'h01);
        rd_reg(TCF_IRQ_STATUS_ADDR, 8'h00);
        chk("irq cleared", 8'h00, {7'h00, irq});
        wr_reg(TCF_CTRL_ADDR, 8'h00);
        tcf_partner_inst.event_pulse(2);
        rd_reg(TCF_CTRL_ADDR, 8'h80);
        wr_reg(TCF_CTRL_ADDR, 8'h21);
        n_rel = 0;
        tcf_partner_inst.event_pulse(0);
        rd_reg(TCF_CTRL_ADDR, 8'h21);
        chk("baud reloads", 8'h01, 8'(n_rel));
        wr_reg(TCF_MODE_ADDR, 8'h01);
        wr_reg(TCF_CTRL_ADDR, 8'h00);
        chk("down count enable", 8'h01, {7'h00, dce});
        tcf_partner_inst.event_pulse(0);
        rd_reg(TCF_CTRL_ADDR, 8'hc0);
        wr_reg(TCF_CTRL_ADDR, 8'h00);
        tcf_partner_inst.event_pulse(1);
        rd_reg(TCF_CTRL_ADDR, 8'h40);
        wr_reg(TCF_MODE_ADDR, 8'h00);
        $display("test counter events done");
        wr_reg(TCF_IRQ_MASK_ADDR, 8'h02);
        chk("down count disabled", 8'h00, {7'h00, dce});
        n_rel = 0;
        for (int i = 0; i < 4; i++) begin
            wr_reg(TCF_CTRL_ADDR, pin_ctrl[i]);
            wr_reg(TCF_IRQ_STATUS_ADDR, 8'h03);
            tcf_partner_inst.pin_fall();
            rd_reg(TCF_CTRL_ADDR, pin_exp[i]);
            repeat (8) @(posedge core_clk_in);
            rd_reg(TCF_CTRL_ADDR, pin_exp[i]);
            chk("pin irq", {7'h00, pin_exp[i][6]}, {7'h00, irq});
        end
        chk("pin reloads", 8'h01, 8'(n_rel));
        chk("pin captures", 8'h01, 8'(n_cap));
        chk("pin counts", 8'h01, 8'(n_ext));
        $display("test trigger pin done");
        wr_reg(TCF_CTRL_ADDR, 8'h00);
        wr_reg(TCF_IRQ_STATUS_ADDR, 8'h03);
        wr_reg(TCF_CTRL_ADDR, 8'h40);
        rd_reg(TCF_IRQ_STATUS_ADDR, 8'h02);
        chk("soft irq", 8'h01, {7'h00, irq});
        wr_reg(TCF_IRQ_MASK_ADDR, 8'h00);
        rd_reg(TCF_IRQ_MASK_ADDR, 8'h00);
        chk("masked irq", 8'h00, {7'h00, irq});
        $display("test software flag done");
        repeat (3) @(posedge core_clk_in);
        conclude();
    end
endmodule : tcf_timer2_flags_bench

// [verilog/tcf_pin_edge.sv]
// Trigger pin synchroniser and falling edge detector
`timescale 1ns/100ps
module tcf_pin_edge (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Pin and edge pulse
    input wire logic pin_in,
    output logic fall_out
);
    import tcf_pkg::*;

    typedef struct packed {
        logic [TCF_SYNC_STAGES-1:0] sync;
        logic level;
        logic fall;
    } tcf_edge_state_t;

    tcf_edge_state_t st;
    tcf_edge_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.sync = {st.sync[TCF_SYNC_STAGES-2:0], pin_in};
        next_st.fall = 1'b0;
        // Accept a change only once stages two and three agree
        if (st.sync[1] == st.sync[2]) begin
            next_st.level = st.sync[2];
            next_st.fall = st.level & ~st.sync[2];
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '{sync: {TCF_SYNC_STAGES{TCF_PIN_IDLE}}, level: TCF_PIN_IDLE, fall: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign fall_out = st.fall;

endmodule : tcf_pin_edge

// [verilog/tcf_pkg.sv]
// Shared constants for the second timer control and flag block
package tcf_pkg;

    // Register offsets
    localparam logic [7:0] TCF_CTRL_ADDR = 8'hc8;
    localparam logic [7:0] TCF_IRQ_STATUS_ADDR = 8'hd0;
    localparam logic [7:0] TCF_IRQ_MASK_ADDR = 8'hd1;
    localparam logic [7:0] TCF_MODE_ADDR = 8'hd2;

    // Control register field positions
    localparam int TCF_OVF_BIT = 7;
    localparam int TCF_EXT_BIT = 6;
    localparam int TCF_RX_SEL_BIT = 5;
    localparam int TCF_TX_SEL_BIT = 4;
    localparam int TCF_EXEN_BIT = 3;
    localparam int TCF_RUN_BIT = 2;
    localparam int TCF_CNT_SRC_BIT = 1;
    localparam int TCF_CPRL_BIT = 0;

    // Interrupt status and mask field positions
    localparam int TCF_IRQ_OVF_BIT = 0;
    localparam int TCF_IRQ_EXT_BIT = 1;
    localparam int TCF_IRQ_W = 2;

    // Mode register field positions
    localparam int TCF_MODE_DCE_BIT = 0;

    // Reset values
    localparam logic [7:0] TCF_CTRL_RST = 8'h00;
    localparam logic [1:0] TCF_IRQ_STATUS_RST = 2'h0;
    localparam logic [1:0] TCF_IRQ_MASK_RST = 2'h0;
    localparam logic TCF_MODE_DCE_RST = 1'b0;
    localparam logic TCF_PIN_IDLE = 1'b1;

    // Synchroniser depth for the trigger pin
    localparam int TCF_SYNC_STAGES = 3;

endpackage : tcf_pkg

// [verilog/tcf_timer2_flags.sv]
// Second timer control register, flags, baud selects and interrupt
// Functional notes
// - Overflow flag, bit 7, sets when the count rolls past its maximum.
// - Counting down, overflow flag also sets when count equals the capture value.
// - Hardware sets overflow flag only while both baud selects are zero.
// - Software writes may set the overflow flag, and clear it unless hardware sets it in the same cycle.
// - External flag, bit 6, sets on pin falling edge or counter wrap per settings.
// - Software writes may set the external flag.
// - External flag set by pin or software raises interrupt when enabled.
// - Bit 5 picks the receive baud time base for serial modes 1 and 3.
// - Receive select zero uses timer 1, one uses timer 2 as baud generator.
// - Bit 4 picks the transmit baud time base for serial modes 1 and 3.
// - Transmit select zero uses timer 1, one uses timer 2 as baud generator.
// - Without external enable the pin only feeds the count pulse; with it edges also capture or reload, not in baud use.
// - In baud use capture select is ignored and every overflow reloads.
`timescale 1ns/100ps
module tcf_timer2_flags #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Trigger pin
    input wire logic external_trigger_pin_in,
    // Counter events
    input wire logic timer_rollover_in,
    input wire logic timer_underflow_in,
    input wire logic timer_count_down_in,
    input wire logic count_equals_capture_in,
    // Baud source selects
    output logic rx_baud_from_timer2_out,
    output logic tx_baud_from_timer2_out,
    output logic baud_generator_mode_out,
    // Counter control
    output logic second_timer_run_out,
    output logic count_source_select_out,
    output logic down_count_enable_out,
    output logic capture_strobe_out,
    output logic reload_strobe_out,
    output logic external_count_pulse_out,
    // Interrupt
    output logic irq_out
);
    import tcf_pkg::*;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // Narrower buses cannot reach the register offsets
    if (ADDR_W < 8) begin : g_addr_w_check
        $error("ADDR_W must be at least 8");
    end

    typedef struct packed {
        logic [7:0] ctrl;
        logic [TCF_IRQ_W-1:0] irq_status;
        logic [TCF_IRQ_W-1:0] irq_mask;
        logic down_count_enable;
        logic [7:0] rdata;
        logic capture;
        logic reload;
        logic ext_count;
    } tcf_state_t;

    tcf_state_t st;
    tcf_state_t next_st;

    logic pin_fall;
    logic baud_mode;
    logic ctrl_wr;
    logic ovf_event;
    logic ext_pin_event;
    logic ext_cnt_event;
    logic ovf_rise;
    logic ext_rise;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] target);
        addr_hit = (a == ADDR_W'(target));
    endfunction : addr_hit

    tcf_pin_edge tcf_pin_edge_inst (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(external_trigger_pin_in),
        .fall_out(pin_fall)
    );

    always_comb begin
        next_st = st;
        baud_mode = st.ctrl[TCF_RX_SEL_BIT] | st.ctrl[TCF_TX_SEL_BIT];
        ctrl_wr = reg_wr_in & addr_hit(reg_addr_in, TCF_CTRL_ADDR);
        // Overflow or down-count match, blocked in baud use
        ovf_event = ~baud_mode & (timer_rollover_in | (timer_count_down_in & count_equals_capture_in));
        ext_pin_event = pin_fall & st.ctrl[TCF_EXEN_BIT] & ~baud_mode;
        ext_cnt_event = st.down_count_enable & ~baud_mode & (timer_rollover_in | timer_underflow_in);

        // Control register write
        if (ctrl_wr) begin
            next_st.ctrl = reg_wdata_in;
        end
        // Hardware set wins over a software clear in the same cycle
        next_st.ctrl[TCF_OVF_BIT] = next_st.ctrl[TCF_OVF_BIT] | ovf_event;
        next_st.ctrl[TCF_EXT_BIT] = next_st.ctrl[TCF_EXT_BIT] | ext_pin_event | ext_cnt_event;

        // Interrupt sources on rising flags
        ovf_rise = next_st.ctrl[TCF_OVF_BIT] & ~st.ctrl[TCF_OVF_BIT];
        ext_rise = next_st.ctrl[TCF_EXT_BIT] & ~st.ctrl[TCF_EXT_BIT];
        if (reg_wr_in && addr_hit(reg_addr_in, TCF_IRQ_STATUS_ADDR)) begin
            next_st.irq_status = st.irq_status & ~reg_wdata_in[TCF_IRQ_W-1:0];
        end
        next_st.irq_status[TCF_IRQ_OVF_BIT] = next_st.irq_status[TCF_IRQ_OVF_BIT] | ovf_rise;
        next_st.irq_status[TCF_IRQ_EXT_BIT] = next_st.irq_status[TCF_IRQ_EXT_BIT] | ext_rise;
        if (reg_wr_in && addr_hit(reg_addr_in, TCF_IRQ_MASK_ADDR)) begin
            next_st.irq_mask = reg_wdata_in[TCF_IRQ_W-1:0];
        end
        if (reg_wr_in && addr_hit(reg_addr_in, TCF_MODE_ADDR)) begin
            next_st.down_count_enable = reg_wdata_in[TCF_MODE_DCE_BIT];
        end

        // Capture and reload strobes
        next_st.capture = ext_pin_event & st.ctrl[TCF_CPRL_BIT];
        next_st.reload = (ext_pin_event & ~st.ctrl[TCF_CPRL_BIT])
            | (timer_rollover_in & (baud_mode | ~st.ctrl[TCF_CPRL_BIT]));
        next_st.ext_count = pin_fall & st.ctrl[TCF_CNT_SRC_BIT] & st.ctrl[TCF_RUN_BIT];

        // Read data valid the cycle after the strobe only
        next_st.rdata = 8'h00;
        if (reg_rd_in) begin
            if (addr_hit(reg_addr_in, TCF_CTRL_ADDR)) begin
                next_st.rdata = st.ctrl;
            end else if (addr_hit(reg_addr_in, TCF_IRQ_STATUS_ADDR)) begin
                next_st.rdata = {6'h00, st.irq_status};
            end else if (addr_hit(reg_addr_in, TCF_IRQ_MASK_ADDR)) begin
                next_st.rdata = {6'h00, st.irq_mask};
            end else if (addr_hit(reg_addr_in, TCF_MODE_ADDR)) begin
                next_st.rdata = {7'h00, st.down_count_enable};
            end else begin
                next_st.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '{ctrl: TCF_CTRL_RST, irq_status: TCF_IRQ_STATUS_RST, irq_mask: TCF_IRQ_MASK_RST,
                    down_count_enable: TCF_MODE_DCE_RST, rdata: 8'h00, capture: 1'b0, reload: 1'b0,
                    ext_count: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_out = st.rdata;
    assign rx_baud_from_timer2_out = st.ctrl[TCF_RX_SEL_BIT];
    assign tx_baud_from_timer2_out = st.ctrl[TCF_TX_SEL_BIT];
    assign baud_generator_mode_out = st.ctrl[TCF_RX_SEL_BIT] | st.ctrl[TCF_TX_SEL_BIT];
    assign second_timer_run_out = st.ctrl[TCF_RUN_BIT];
    assign count_source_select_out = st.ctrl[TCF_CNT_SRC_BIT];
    assign down_count_enable_out = st.down_count_enable;
    assign capture_strobe_out = st.capture;
    assign reload_strobe_out = st.reload;
    assign external_count_pulse_out = st.ext_count;
    assign irq_out = |(st.irq_status & st.irq_mask);

    // Checks

    AST_OVF_ROLLOVER: assert property (
        timer_rollover_in && !baud_mode |=> st.ctrl[TCF_OVF_BIT])
        else $error("overflow flag not set after rollover");

    AST_OVF_DOWN_MATCH: assert property (
        timer_count_down_in && count_equals_capture_in && !baud_mode |=> st.ctrl[TCF_OVF_BIT])
        else $error("overflow flag not set on down-count match");

    AST_OVF_BAUD_HOLD: assert property (
        baud_mode && !ctrl_wr |=> st.ctrl[TCF_OVF_BIT] == $past(st.ctrl[TCF_OVF_BIT]))
        else $error("overflow flag changed by hardware in baud use");

    AST_OVF_SW_WRITE: assert property (
        ctrl_wr && !ovf_event |=> st.ctrl[TCF_OVF_BIT] == $past(reg_wdata_in[TCF_OVF_BIT]))
        else $error("software write to overflow flag lost");

    AST_EXT_PIN_SET: assert property (
        pin_fall && st.ctrl[TCF_EXEN_BIT] && !baud_mode |=> st.ctrl[TCF_EXT_BIT])
        else $error("external flag not set by pin edge");

    AST_EXT_SW_SET: assert property (
        ctrl_wr && reg_wdata_in[TCF_EXT_BIT] |=> st.ctrl[TCF_EXT_BIT])
        else $error("software set of external flag lost");

    AST_EXT_STICKY: assert property (
        st.ctrl[TCF_EXT_BIT] && !ctrl_wr |=> st.ctrl[TCF_EXT_BIT])
        else $error("external flag cleared without software");

    AST_EXT_IRQ: assert property (
        !st.ctrl[TCF_EXT_BIT] ##1 st.ctrl[TCF_EXT_BIT] && st.irq_mask[TCF_IRQ_EXT_BIT] |-> irq_out)
        else $error("interrupt missing after external flag set");

    AST_RX_SELECT: assert property (
        ctrl_wr |=> rx_baud_from_timer2_out == $past(reg_wdata_in[TCF_RX_SEL_BIT])
            && (baud_generator_mode_out || !rx_baud_from_timer2_out))
        else $error("receive baud select wrong");

    AST_TX_SELECT: assert property (
        ctrl_wr |=> tx_baud_from_timer2_out == $past(reg_wdata_in[TCF_TX_SEL_BIT])
            && (baud_generator_mode_out || !tx_baud_from_timer2_out))
        else $error("transmit baud select wrong");

    AST_PIN_IGNORED: assert property (
        pin_fall && !st.ctrl[TCF_EXEN_BIT] && !st.ctrl[TCF_EXT_BIT] && !ctrl_wr && !ext_cnt_event
            |=> !st.ctrl[TCF_EXT_BIT] && !capture_strobe_out)
        else $error("pin edge acted while external enable clear");

    AST_BAUD_NO_CAPTURE: assert property (
        baud_mode |=> !capture_strobe_out)
        else $error("capture in baud use");

    AST_BAUD_RELOAD: assert property (
        baud_mode && timer_rollover_in |=> reload_strobe_out)
        else $error("no reload after overflow in baud use");

    AST_OVF_STATUS_SET: assert property (
        ovf_event && !st.ctrl[TCF_OVF_BIT] |=> st.irq_status[TCF_IRQ_OVF_BIT])
        else $error("overflow status bit not set");

    AST_OVF_NO_STRAY: assert property (
        !ovf_event && !ctrl_wr && !st.ctrl[TCF_OVF_BIT] |=> !st.ctrl[TCF_OVF_BIT])
        else $error("overflow flag set without cause");

    AST_EXT_CNT_SET: assert property (
        ext_cnt_event |=> st.ctrl[TCF_EXT_BIT])
        else $error("external flag not set by counter wrap");

    AST_EXT_NO_STRAY: assert property (
        !ext_pin_event && !ext_cnt_event && !ctrl_wr && !st.ctrl[TCF_EXT_BIT] |=> !st.ctrl[TCF_EXT_BIT])
        else $error("external flag set without cause");

    AST_PIN_BAUD_BLOCK: assert property (
        baud_mode && pin_fall && !timer_rollover_in |=> !reload_strobe_out)
        else $error("pin edge reloaded in baud use");

    AST_PIN_CAPTURE: assert property (
        pin_fall && st.ctrl[TCF_EXEN_BIT] && st.ctrl[TCF_CPRL_BIT] && !baud_mode |=> capture_strobe_out)
        else $error("pin edge gave no capture");

    AST_PIN_RELOAD: assert property (
        pin_fall && st.ctrl[TCF_EXEN_BIT] && !st.ctrl[TCF_CPRL_BIT] && !baud_mode |=> reload_strobe_out)
        else $error("pin edge gave no reload");

    AST_ROLL_RELOAD: assert property (
        timer_rollover_in && !st.ctrl[TCF_CPRL_BIT] |=> reload_strobe_out)
        else $error("no reload after overflow");

    AST_CAPTURE_CAUSE: assert property (
        !pin_fall |=> !capture_strobe_out)
        else $error("capture without pin edge");

    AST_RELOAD_CAUSE: assert property (
        !pin_fall && !timer_rollover_in |=> !reload_strobe_out)
        else $error("reload without cause");

    AST_EXT_SW_IRQ: assert property (
        ctrl_wr && reg_wdata_in[TCF_EXT_BIT] && !st.ctrl[TCF_EXT_BIT] |=> st.irq_status[TCF_IRQ_EXT_BIT])
        else $error("software set of external flag raised no interrupt");

    AST_STATUS_STICKY: assert property (
        st.irq_status[TCF_IRQ_EXT_BIT] && !(reg_wr_in && addr_hit(reg_addr_in, TCF_IRQ_STATUS_ADDR))
            |=> st.irq_status[TCF_IRQ_EXT_BIT])
        else $error("external status bit lost");

    AST_STATUS_CLEAR: assert property (
        reg_wr_in && addr_hit(reg_addr_in, TCF_IRQ_STATUS_ADDR) && reg_wdata_in[TCF_IRQ_EXT_BIT] && !ext_rise
            |=> !st.irq_status[TCF_IRQ_EXT_BIT])
        else $error("external status bit not cleared");

    AST_IRQ_MASKED: assert property (
        st.irq_mask == '0 |-> !irq_out)
        else $error("interrupt raised while fully masked");

    AST_IRQ_RAISED: assert property (
        st.irq_status[TCF_IRQ_EXT_BIT] && st.irq_mask[TCF_IRQ_EXT_BIT] |-> irq_out)
        else $error("interrupt missing for enabled external status");

    AST_RDATA_IDLE: assert property (
        !reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not zero outside a read");

    AST_RDATA_CTRL: assert property (
        reg_rd_in && addr_hit(reg_addr_in, TCF_CTRL_ADDR) |=> reg_rdata_out == $past(st.ctrl))
        else $error("control read data wrong");

    AST_EXT_COUNT_PULSE: assert property (
        pin_fall && st.ctrl[TCF_CNT_SRC_BIT] && st.ctrl[TCF_RUN_BIT] |=> external_count_pulse_out)
        else $error("pin edge not counted");

    AST_EXT_COUNT_CAUSE: assert property (
        !pin_fall |=> !external_count_pulse_out)
        else $error("count pulse without pin edge");

    AST_FALL_SINGLE: assert property (
        pin_fall |=> !pin_fall)
        else $error("edge pulse longer than one cycle");

    COV_PIN_CAPTURE: cover property (pin_fall && st.ctrl[TCF_EXEN_BIT] && st.ctrl[TCF_CPRL_BIT] ##1 capture_strobe_out);
    COV_BAUD_RELOAD: cover property (baud_mode && timer_rollover_in ##1 reload_strobe_out);
    COV_OVF_IRQ: cover property (ovf_event && st.irq_mask[TCF_IRQ_OVF_BIT] ##1 irq_out);
    COV_IRQ_CLEAR: cover property (irq_out ##1 !irq_out);
    COV_EXT_COUNT: cover property (pin_fall && st.ctrl[TCF_RUN_BIT] ##1 external_count_pulse_out);

endmodule : tcf_timer2_flags
